// ### rtl/hsse_core.v
`timescale 1ns/1ps
`include "hsse_defs.vh"
module hsse_core (
    // Clock and reset
    input wire clk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Core state
    output reg haltMode_r,
    output reg [7:0] watchdogCount_r,
    output reg [7:0] watchdogPrescaler_r
);

// ==========================================================
// Storage
reg [7:0] accumulator_r;
reg [7:0] regFile_r [0:127];
reg [7:0] specialPage_r [0:31];
reg carryFlag_r;
reg digitCarryFlag_r;
reg zeroFlag_r;
reg timeoutFlagN_r;
reg powerDownFlagN_r;
integer i;

// ==========================================================
// Bus decode
wire setupAcc = psel && !penable;
wire wrAcc = psel && penable && pwrite && pready;
wire isCtrl = (paddr == `HSSE_ADDR_CTRL);
wire isAcc = (paddr == `HSSE_ADDR_ACC);
wire isStat = (paddr == `HSSE_ADDR_STAT);
wire isWdt = (paddr == `HSSE_ADDR_WDT);
wire isPresc = (paddr == `HSSE_ADDR_PRESC);
wire isSpg = (paddr[11:7] == 5'h02) && (paddr[1:0] == 2'h0);
wire isReg = (paddr[11:9] == 3'h1) && (paddr[1:0] == 2'h0);
wire [4:0] spgIdx = paddr[6:2];
wire [6:0] regIdx = paddr[8:2];
wire mapped = isCtrl | isAcc | isStat | isWdt | isPresc | isSpg | isReg;

// ==========================================================
// Instruction fields from a CTRL write
wire [2:0] opCode = pwdata[`HSSE_CTRL_OP_MSB:`HSSE_CTRL_OP_LSB];
wire [6:0] operand = pwdata[`HSSE_CTRL_OPER_MSB:`HSSE_CTRL_OPER_LSB];
wire destReg = pwdata[`HSSE_CTRL_DEST_BIT];
wire wake = pwdata[`HSSE_CTRL_WAKE_BIT];
wire execNow = wrAcc && isCtrl && !haltMode_r;

// ==========================================================
// Datapath: subtract and swap
wire [7:0] srcVal = regFile_r[operand];
wire [8:0] subFull = {1'b0, srcVal} + {1'b0, ~accumulator_r} + 9'h001;
wire [4:0] subLow = {1'b0, srcVal[3:0]} + {1'b0, ~accumulator_r[3:0]} + 5'h01;
wire [7:0] subRes = subFull[7:0];
wire [7:0] swapRes = {srcVal[3:0], srcVal[7:4]};
wire [7:0] opRes = (opCode == `HSSE_OP_SUB) ? subRes : swapRes;

// ==========================================================
// APB handshake, one wait-free access phase
always @(posedge clk) begin
    if (rst) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end else begin
        pready <= setupAcc;
        pslverr <= setupAcc && !mapped;
        if (setupAcc && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (isCtrl)
                prdata <= {31'h0000_0000, haltMode_r};
            else if (isAcc)
                prdata <= {24'h00_0000, accumulator_r};
            else if (isStat)
                prdata <= {26'h000_0000, haltMode_r, timeoutFlagN_r, powerDownFlagN_r,
                    zeroFlag_r, digitCarryFlag_r, carryFlag_r};
            else if (isWdt)
                prdata <= {24'h00_0000, watchdogCount_r};
            else if (isPresc)
                prdata <= {24'h00_0000, watchdogPrescaler_r};
            else if (isSpg)
                prdata <= {24'h00_0000, specialPage_r[spgIdx]};
            else if (isReg)
                prdata <= {24'h00_0000, regFile_r[regIdx]};
        end else if (!setupAcc) begin
            prdata <= 32'h0000_0000;
        end
    end
end

// ==========================================================
// Instruction execution and direct register writes
always @(posedge clk) begin
    if (rst) begin
        accumulator_r <= `HSSE_RST_BYTE;
        carryFlag_r <= 1'b0;
        digitCarryFlag_r <= 1'b0;
        zeroFlag_r <= 1'b0;
        timeoutFlagN_r <= 1'b1;
        powerDownFlagN_r <= 1'b1;
        haltMode_r <= 1'b0;
        watchdogCount_r <= `HSSE_WDT_CLR;
        watchdogPrescaler_r <= `HSSE_WDT_CLR;
        for (i = 0; i < 128; i = i + 1)
            regFile_r[i] <= `HSSE_RST_BYTE;
        for (i = 0; i < 32; i = i + 1)
            specialPage_r[i] <= `HSSE_RST_BYTE;
    end else if (execNow) begin
        case (opCode)
            `HSSE_OP_HALT: begin
                watchdogCount_r <= `HSSE_WDT_CLR;
                watchdogPrescaler_r <= `HSSE_WDT_CLR;
                haltMode_r <= 1'b1;
                timeoutFlagN_r <= 1'b1;
                powerDownFlagN_r <= 1'b0;
            end
            `HSSE_OP_STORE_SPECIAL_PAGE_INSTR: begin
                specialPage_r[operand[4:0]] <= accumulator_r;
            end
            `HSSE_OP_SUB, `HSSE_OP_SWAP: begin
                if (destReg)
                    regFile_r[operand] <= opRes;
                else
                    accumulator_r <= opRes;
                if (opCode == `HSSE_OP_SUB) begin
                    zeroFlag_r <= (subRes == 8'h00);
                    digitCarryFlag_r <= subLow[4];
                    carryFlag_r <= subFull[8];
                end
            end
            default: begin
                accumulator_r <= accumulator_r;
            end
        endcase
    end else if (wrAcc && isCtrl && haltMode_r && wake) begin
        // External wake releases halt
        haltMode_r <= 1'b0;
    end else if (wrAcc) begin
        if (isAcc)
            accumulator_r <= pwdata[7:0];
        else if (isWdt)
            watchdogCount_r <= pwdata[7:0];
        else if (isPresc)
            watchdogPrescaler_r <= pwdata[7:0];
        else if (isSpg)
            specialPage_r[spgIdx] <= pwdata[7:0];
        else if (isReg)
            regFile_r[regIdx] <= pwdata[7:0];
    end
end

endmodule // hsse_core

// ### rtl/hsse_defs.vh
`ifndef HSSE_DEFS_VH
`define HSSE_DEFS_VH
// ==========================================================
// Register map (byte addresses)
`define HSSE_ADDR_CTRL 12'h000
`define HSSE_ADDR_ACC 12'h004
`define HSSE_ADDR_STAT 12'h008
`define HSSE_ADDR_WDT 12'h00C
`define HSSE_ADDR_PRESC 12'h010
`define HSSE_ADDR_SPG_BASE 12'h100
`define HSSE_ADDR_REG_BASE 12'h200
// ==========================================================
// Instruction codes in CTRL[10:8]
`define HSSE_OP_NOP 3'h0
`define HSSE_OP_HALT 3'h1
`define HSSE_OP_STORE_SPECIAL_PAGE_INSTR 3'h2
`define HSSE_OP_SUB 3'h3
`define HSSE_OP_SWAP 3'h4
// ==========================================================
// CTRL field positions
`define HSSE_CTRL_OPER_LSB 0
`define HSSE_CTRL_OPER_MSB 6
`define HSSE_CTRL_DEST_BIT 7
`define HSSE_CTRL_OP_LSB 8
`define HSSE_CTRL_OP_MSB 10
`define HSSE_CTRL_WAKE_BIT 16
// ==========================================================
// Status bit positions
`define HSSE_ST_CARRY 0
`define HSSE_ST_DC 1
`define HSSE_ST_ZERO 2
`define HSSE_ST_PD 3
`define HSSE_ST_TO 4
`define HSSE_ST_HALT 5
// ==========================================================
// Reset values
`define HSSE_RST_BYTE 8'h00
`define HSSE_RST_STAT 5'h18
`define HSSE_WDT_CLR 8'h00
`endif

// ### tb/hsse_core_bench.sv
`timescale 1ns/1ps
`include "hsse_defs.vh"
// ====================
// Instruction bench
module hsse_core_bench;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, haltMode_r, rerr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
    logic [7:0] watchdogCount_r, watchdogPrescaler_r;
    int err_total = 0, samples_checked = 0, cyc = 0;
    // Clock
    always #2.5 clk = ~clk;
    hsse_core u_hsse_core (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .haltMode_r, .watchdogCount_r, .watchdogPrescaler_r);
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            final_report();
        end
    end
    task automatic final_report();
        if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One bus transfer, then an idle cycle
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // Hold the request until pready is sampled high at a rising edge
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(a, 0, 0);
        cmp(rdat, e);
        cmp(rerr, 0);
    endtask
    function automatic logic [11:0] ra(input logic [6:0] r);
        return `HSSE_ADDR_REG_BASE + {3'h0, r, 2'h0};
    endfunction
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        xfer(`HSSE_ADDR_ACC, 1, 8'h06);
        xfer(ra(5), 1, 8'h05);
        xfer(`HSSE_ADDR_CTRL, 1, 32'h0000_0385);
        rd(ra(5), 8'hFF);
        rd(`HSSE_ADDR_STAT, 8'h18);
        rd(`HSSE_ADDR_ACC, 8'h06);
        xfer(`HSSE_ADDR_ACC, 1, 8'h05);
        xfer(ra(6), 1, 8'h06);
        xfer(`HSSE_ADDR_CTRL, 1, 32'h0000_0306);
        rd(`HSSE_ADDR_ACC, 8'h01);
        rd(ra(6), 8'h06);
        rd(`HSSE_ADDR_STAT, 8'h1B);
        xfer(ra(127), 1, 8'h01);
        xfer(`HSSE_ADDR_CTRL, 1, 32'h0000_03FF);
        rd(ra(127), 8'h00);
        rd(`HSSE_ADDR_STAT, 8'h1F);
        xfer(ra(0), 1, 8'hA5);
        xfer(ra(1), 1, 8'h3C);
        xfer(`HSSE_ADDR_CTRL, 1, 32'h0000_0480);
        xfer(`HSSE_ADDR_CTRL, 1, 32'h0000_0401);
        rd(ra(0), 8'h5A);
        rd(`HSSE_ADDR_ACC, 8'hC3);
        xfer(`HSSE_ADDR_CTRL, 1, 32'h0000_021F);
        rd(`HSSE_ADDR_SPG_BASE + 12'h07C, 8'hC3);
        rd(`HSSE_ADDR_STAT, 8'h1F);
        xfer(12'hFFC, 0, 0);
        cmp(rerr, 1);
        cmp(rdat, 0);
        xfer(`HSSE_ADDR_WDT, 1, 8'h33);
        xfer(`HSSE_ADDR_PRESC, 1, 8'h44);
        xfer(`HSSE_ADDR_CTRL, 1, 32'h0000_0100);
        cmp(haltMode_r, 1);
        rd(`HSSE_ADDR_WDT, 8'h00);
        rd(`HSSE_ADDR_PRESC, 8'h00);
        rd(`HSSE_ADDR_STAT, 8'h37);
        xfer(`HSSE_ADDR_CTRL, 1, 32'h0000_03FF);
        rd(ra(127), 8'h00);
        xfer(`HSSE_ADDR_CTRL, 1, 32'h0001_0000);
        cmp(haltMode_r, 0);
        final_report();
    end
endmodule // hsse_core_bench

// ### tb/hsse_core_sva.sv
`timescale 1ns/1ps
`include "hsse_defs.vh"
// ====================
// Bus and halt checks
module hsse_core_sva (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Core state
    input wire haltMode_r,
    input wire [7:0] watchdogCount_r,
    input wire [7:0] watchdogPrescaler_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Halt instruction accepted while running
    sequence haltWr;
        psel && penable && pready && pwrite && paddr == `HSSE_ADDR_CTRL
            && pwdata[10:8] == `HSSE_OP_HALT && !haltMode_r;
    endsequence
    sequence setupPh;
        psel && !penable;
    endsequence
    chk_ready_next: assert property (setupPh |=> pready) else $error("no ready after setup");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data leaks");
    chk_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("upper bits set");
    chk_halt_clear:
        assert property (haltWr |=> watchdogCount_r == 8'h00 && watchdogPrescaler_r == 8'h00) else $error("wdt kept");
    chk_halt_enter:
        assert property (haltWr |=> haltMode_r) else $error("halt not entered");
    chk_halt_stays:
        assert property (haltMode_r && !(psel && paddr == `HSSE_ADDR_CTRL) |=> haltMode_r) else $error("halt lost");
endmodule // hsse_core_sva

bind hsse_core hsse_core_sva u_hsse_core_sva (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .haltMode_r, .watchdogCount_r, .watchdogPrescaler_r);
